// ---- prt_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Core reset logic: answers timer events with resets
// ------------------------------------------------------------
module prt_core_model (
  input wire logic clk,
  input wire logic periodic_reset_req,
  input wire logic deep_stop_por_req,
  output logic core_rst_n,
  output logic stop_por_n,
  output logic stop_exit
);
  logic [1:0] rst_cnt;
  logic [1:0] por_cnt;
  initial begin
    rst_cnt = 2'h0;
    por_cnt = 2'h0;
  end
  always @(posedge clk) begin
    if (periodic_reset_req) rst_cnt <= 2'h2;
    else if (rst_cnt != 2'h0) rst_cnt <= rst_cnt - 2'h1;
    // Exit flag outlives the power-on pulse so the block sees its cause
    if (deep_stop_por_req) por_cnt <= 2'h3;
    else if (por_cnt != 2'h0) por_cnt <= por_cnt - 2'h1;
  end
  assign core_rst_n = (rst_cnt == 2'h0);
  // Exit flag rises a cycle before the pulse and falls a cycle after it
  assign stop_por_n = (por_cnt != 2'h2);
  assign stop_exit = (por_cnt != 2'h0);
endmodule : prt_core_model
`default_nettype wire

// ---- prt_defines.svh ----
`ifndef PRT_DEFINES_SVH
`define PRT_DEFINES_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define PRT_ADDR_STATUS 8'h1F
`define PRT_ADDR_CTRL 8'h3A
`define PRT_ADDR_WAKE 8'h39
`define PRT_ADDR_MODE 8'h3B
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define PRT_FLAG_BIT 7
`define PRT_ACK_BIT 6
`define PRT_PSEL_BIT 7
`define PRT_CNT_RESET 6'h3F
`define PRT_WAKE_RESET 6'h3F
`endif

// ---- prt_pkg.sv ----
package prt_pkg;
  typedef enum logic [1:0] {
    PRT_RUN = 2'h0,
    PRT_LIGHT_STOP = 2'h1,
    PRT_DEEP_STOP = 2'h3
  } prt_mode_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prt_bus_s;
  typedef struct packed {
    logic por;
    logic stop_exit;
    logic sys_reset;
  } prt_rst_s;
endpackage : prt_pkg

// ---- prt_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "prt_defines.svh"
module prt_timer #(
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic stop_exit,
  input wire logic sys_reset,
  input wire logic wclk_tick,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic wake_flag,
  output logic wake_irq,
  output logic periodic_reset_req,
  output logic clock_restart_req,
  output logic deep_stop_por_req
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  // por_n marks every power-on, stop exits included; resetn is every reset of the chip.
  // Retained fields reset only on a por_n that is not a stop exit, so every other reset keeps them.
  logic [CW-1:0] periodic_reset_count_r, periodic_reset_count_nxt;
  logic [CW-1:0] wake_interval_count_r, wake_interval_count_nxt;
  logic [CW-1:0] rcnt_r, rcnt_nxt;
  logic [CW-1:0] wcnt_r, wcnt_nxt;
  logic periodic_reset_flag_r, periodic_reset_flag_nxt;
  logic wake_flag_r, wake_flag_nxt;
  logic psel_r, psel_nxt;
  logic fresh_r, fresh_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic preq_r, preq_nxt, wirq_r, wirq_nxt, crst_r, crst_nxt, dpor_r, dpor_nxt;
  prt_pkg::prt_mode_e mode;
  logic wake_evt, rst_evt, wr_ctrl, wr_wake;
  // A power-on that comes from a stop exit must not clear retained bits
  logic true_por_n;

  function automatic logic is_zero(input logic [CW-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  assign true_por_n = por_n | stop_exit;
  assign mode = prt_pkg::prt_mode_e'(mode_r);
  assign wr_ctrl = wr && (addr == `PRT_ADDR_CTRL);
  assign wr_wake = wr && (addr == `PRT_ADDR_WAKE);
  // Wake interval expiry; the wake period is also the reset tick
  assign wake_evt = wclk_tick && !is_zero(wake_interval_count_r)
    && (wcnt_r + 1'b1 >= wake_interval_count_r);
  assign rst_evt = wake_evt && !is_zero(periodic_reset_count_r)
    && (rcnt_r + 1'b1 >= periodic_reset_count_r);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    periodic_reset_count_nxt = periodic_reset_count_r;
    wake_interval_count_nxt = wake_interval_count_r;
    rcnt_nxt = rcnt_r;
    wcnt_nxt = wcnt_r;
    periodic_reset_flag_nxt = periodic_reset_flag_r;
    wake_flag_nxt = wake_flag_r;
    psel_nxt = psel_r;
    fresh_nxt = fresh_r;
    mode_nxt = mode_r;
    rdata_nxt = 8'h00;
    // Counters
    if (wclk_tick && !is_zero(wake_interval_count_r)) begin
      wcnt_nxt = wake_evt ? '0 : wcnt_r + 1'b1;
    end
    if (wake_evt && !is_zero(periodic_reset_count_r)) begin
      rcnt_nxt = rst_evt ? '0 : rcnt_r + 1'b1;
    end
    // Control writes; data bit 7 is ignored except as page select in a status write
    if (wr_ctrl) begin
      if (wdata[`PRT_ACK_BIT]) begin
        periodic_reset_flag_nxt = 1'b0;
      end
      if (wdata[CW-1:0] != periodic_reset_count_r
          && !(is_zero(wdata[CW-1:0])
               && is_zero(wake_interval_count_r))) begin
        periodic_reset_count_nxt = wdata[CW-1:0];
        rcnt_nxt = '0;
      end
    end
    if (wr_wake) begin
      if (wdata[`PRT_ACK_BIT]) begin
        wake_flag_nxt = 1'b0;
      end
      if (wdata[CW-1:0] != wake_interval_count_r
          && !(is_zero(wdata[CW-1:0])
               && is_zero(periodic_reset_count_r))) begin
        wake_interval_count_nxt = wdata[CW-1:0];
        wcnt_nxt = '0;
      end
    end
    if (wr && addr == `PRT_ADDR_STATUS) begin
      psel_nxt = wdata[`PRT_PSEL_BIT];
    end
    if (wr && addr == `PRT_ADDR_MODE) begin
      mode_nxt = wdata[1:0];
    end
    // Set beats a same-cycle acknowledge
    if (rst_evt) begin
      periodic_reset_flag_nxt = 1'b1;
    end
    if (wake_evt) begin
      wake_flag_nxt = 1'b1;
    end
    if (wake_evt || rst_evt) begin
      fresh_nxt = 1'b1;
      mode_nxt = prt_pkg::PRT_RUN;
    end
    if (rd) begin
      case (addr)
        `PRT_ADDR_STATUS: begin
          rdata_nxt[`PRT_PSEL_BIT] = psel_r;
          if (!fresh_r) begin
            rdata_nxt[CW-1:0] = psel_r ? rcnt_r : wcnt_r;
          end
          fresh_nxt = 1'b0;
        end
        `PRT_ADDR_CTRL: begin
          rdata_nxt = {periodic_reset_flag_r, 1'b0,
                       periodic_reset_count_r};
        end
        `PRT_ADDR_WAKE: begin
          rdata_nxt = {wake_flag_r, 1'b0, wake_interval_count_r};
        end
        `PRT_ADDR_MODE: begin
          rdata_nxt = {6'h00, mode_r};
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Requests toward the core and reset logic
  // ------------------------------------------------------------
  always_comb begin
    preq_nxt = 1'b0;
    wirq_nxt = 1'b0;
    crst_nxt = 1'b0;
    dpor_nxt = 1'b0;
    if (wake_evt || rst_evt) begin
      case (mode)
        prt_pkg::PRT_LIGHT_STOP: begin
          crst_nxt = 1'b1;
        end
        prt_pkg::PRT_DEEP_STOP: begin
          dpor_nxt = 1'b1;
        end
        default: begin
          crst_nxt = 1'b0;
        end
      endcase
      preq_nxt = rst_evt;
      wirq_nxt = wake_evt && !rst_evt;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Only a true power-on clears flag and page select
  always_ff @(posedge clk or negedge true_por_n) begin
    if (!true_por_n) begin
      periodic_reset_flag_r <= 1'b0;
    end else begin
      periodic_reset_flag_r <= periodic_reset_flag_nxt;
    end
  end

  // Page select survives power-on that comes from stop exit
  always_ff @(posedge clk or negedge true_por_n) begin
    if (!true_por_n) begin
      psel_r <= 1'b0;
    end else if (stop_exit) begin
      psel_r <= psel_r;
    end else begin
      psel_r <= psel_nxt;
    end
  end

  // Timer fields: any reset presets count; programmed values otherwise kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periodic_reset_count_r <= `PRT_CNT_RESET;
      wake_interval_count_r <= `PRT_WAKE_RESET;
      rcnt_r <= '0;
      wcnt_r <= '0;
      wake_flag_r <= 1'b0;
      fresh_r <= 1'b0;
      mode_r <= 2'h0;
      rdata_r <= 8'h00;
      preq_r <= 1'b0;
      wirq_r <= 1'b0;
      crst_r <= 1'b0;
      dpor_r <= 1'b0;
    end else begin
      periodic_reset_count_r <= periodic_reset_count_nxt;
      wake_interval_count_r <= wake_interval_count_nxt;
      rcnt_r <= rcnt_nxt;
      wcnt_r <= wcnt_nxt;
      wake_flag_r <= wake_flag_nxt;
      fresh_r <= fresh_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
      preq_r <= preq_nxt;
      wirq_r <= wirq_nxt;
      crst_r <= crst_nxt;
      dpor_r <= dpor_nxt;
    end
  end

  assign rdata = rdata_r;
  assign wake_flag = wake_flag_r;
  assign wake_irq = wake_flag_r; // Pending until acknowledged
  assign periodic_reset_req = preq_r;
  assign clock_restart_req = crst_r;
  assign deep_stop_por_req = dpor_r;
  // sys_reset is absorbed by resetn externally; kept for visibility
  logic unused_sys;
  assign unused_sys = sys_reset ^ wirq_r;
endmodule : prt_timer
`default_nettype wire

// ---- prt_timer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks
// ------------------------------------------------------------
module prt_timer_checker #(
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wclk_tick,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic wake_flag,
  input wire logic wake_irq,
  input wire logic periodic_reset_req,
  input wire logic clock_restart_req,
  input wire logic deep_stop_por_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_ack;
    wr && addr == 8'h3A && wdata[6];
  endsequence
  sequence s_rd_ctrl;
    rd && addr == 8'h3A;
  endsequence
  property p_irq; wake_irq == wake_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq not flag");
  property p_idle; !rd |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_ctl6; s_rd_ctrl |=> !rdata[6]; endproperty
  a_ctl6: assert property (p_ctl6) else $error("ack bit read");
  property p_st6; rd && addr == 8'h1F |=> !rdata[6]; endproperty
  a_st6: assert property (p_st6) else $error("status bit 6 set");
  property p_prp; periodic_reset_req |=> !periodic_reset_req; endproperty
  a_prp: assert property (p_prp) else $error("reset pulse long");
  property p_wtick; $rose(wake_flag) |-> $past(wclk_tick); endproperty
  a_wtick: assert property (p_wtick) else $error("flag w/o tick");
  property p_wack; wr && addr == 8'h39 && wdata[6] && !wclk_tick |=> !wake_flag;
  endproperty
  a_wack: assert property (p_wack) else $error("wake ack failed");
  property p_crp; clock_restart_req |=> !clock_restart_req; endproperty
  a_crp: assert property (p_crp) else $error("restart pulse long");
  property p_dsp; $rose(deep_stop_por_req) |-> $past(wclk_tick); endproperty
  a_dsp: assert property (p_dsp) else $error("deep exit w/o tick");
  property p_fack; s_ack ##2 s_rd_ctrl |=> !rdata[7]; endproperty
  a_fack: assert property (p_fack) else $error("flag ack failed");
endmodule : prt_timer_checker
bind prt_timer prt_timer_checker #(.CW(CW)) chk_u (
  .clk(clk), .resetn(resetn), .wclk_tick(wclk_tick), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wake_flag(wake_flag),
  .wake_irq(wake_irq), .periodic_reset_req(periodic_reset_req),
  .clock_restart_req(clock_restart_req),
  .deep_stop_por_req(deep_stop_por_req));
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module tb_top;
  logic clk, rst_n, tb_por_n, wclk_tick, wr, rd;
  logic [7:0] addr, wdata, rdata;
  logic wake_flag, pr_req, cr_req, ds_req, core_rst_n, s_por_n, s_exit;
  int mismatches = 0, cmp_count = 0, cyc = 0, n_pr = 0, n_cr = 0, n_ds = 0;
  prt_timer #(.CW(6)) dut_u (.clk(clk), .resetn(rst_n & core_rst_n & s_por_n),
    .por_n(tb_por_n & s_por_n), .stop_exit(s_exit), .sys_reset(!core_rst_n),
    .wclk_tick(wclk_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wake_flag(wake_flag), .wake_irq(),
    .periodic_reset_req(pr_req), .clock_restart_req(cr_req),
    .deep_stop_por_req(ds_req));
  prt_core_model core_u (.clk(clk), .periodic_reset_req(pr_req),
    .deep_stop_por_req(ds_req), .core_rst_n(core_rst_n),
    .stop_por_n(s_por_n), .stop_exit(s_exit));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (pr_req === 1'b1) n_pr++;
    if (cr_req === 1'b1) n_cr++;
    if (ds_req === 1'b1) n_ds++;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, e, m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata & m);
  endtask : rd_chk
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) wclk_tick <= 1'b1;
      @(posedge clk) wclk_tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : tick
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    {rst_n, tb_por_n, wclk_tick, wr, rd, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    tb_por_n <= 1'b1;
    rd_chk(8'h3A, 8'h3F, 8'hFF);
    rd_chk(8'h00, 8'h00, 8'hFF);
    wr_reg(8'h1F, 8'h80);
    rd_chk(8'h1F, 8'h80, 8'hC0);
    wr_reg(8'h39, 8'h02);
    wr_reg(8'h3A, 8'h03);
    tick(2);
    chk("wake_flag", 8'h01, {7'h00, wake_flag});
    wr_reg(8'h39, 8'h42);
    @(negedge clk);
    chk("wake_flag", 8'h00, {7'h00, wake_flag});
    wr_reg(8'h3A, 8'h03);
    tick(4);
    repeat (4) @(posedge clk);
    chk("reset pulses", 8'h01, n_pr[7:0]);
    rd_chk(8'h3A, 8'hBF, 8'hFF);
    rd_chk(8'h1F, 8'h80, 8'hFF);
    wr_reg(8'h3A, 8'h7F);
    rd_chk(8'h3A, 8'h3F, 8'hFF);
    wr_reg(8'h3A, 8'hBF);
    rd_chk(8'h3A, 8'h3F, 8'hFF);
    wr_reg(8'h39, 8'h00);
    wr_reg(8'h3A, 8'h00);
    rd_chk(8'h3A, 8'h3F, 8'hFF);
    wr_reg(8'h39, 8'h01);
    wr_reg(8'h3A, 8'h00);
    rd_chk(8'h3A, 8'h00, 8'hFF);
    wr_reg(8'h39, 8'h40);
    tick(1);
    chk("wake_flag", 8'h01, {7'h00, wake_flag});
    wr_reg(8'h39, 8'h41);
    wr_reg(8'h3B, 8'h01);
    tick(1);
    chk("restart", 8'h01, n_cr[7:0]);
    chk("wake_flag", 8'h01, {7'h00, wake_flag});
    wr_reg(8'h39, 8'h41);
    wr_reg(8'h3B, 8'h03);
    tick(1);
    repeat (6) @(posedge clk);
    chk("deep exit", 8'h01, n_ds[7:0]);
    rd_chk(8'h1F, 8'h80, 8'h80);
    rst_n <= 1'b0;
    tb_por_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tb_por_n <= 1'b1;
    rd_chk(8'h1F, 8'h00, 8'h80);
    rd_chk(8'h3A, 8'h3F, 8'hFF);
    results();
  end
endmodule : tb_top
`default_nettype wire
